// ==== verilog/exec_unit_defines.vh ====
`ifndef EXEC_UNIT_DEFINES_VH
`define EXEC_UNIT_DEFINES_VH

// Register offsets on the software port
`define REG_OPCODE   4'h0
`define REG_MADDR    4'h1
`define REG_IMM      4'h2
`define REG_ACC      4'h3
`define REG_STATUS   4'h4
`define REG_PCL      4'h5
`define REG_PCH      4'h6
`define REG_MDATA    4'h7
`define REG_WDOG     4'h8
`define REG_STACKL   4'h9
`define REG_STACKH   4'ha

// Status register bit positions
`define ST_SPILL     0
`define ST_HALF      1
`define ST_NULL      2
`define ST_WRAP      3
`define ST_SLEEP     4
`define ST_EXPIRY    5
`define ST_IRQEN     6
`define ST_BUSY      7

// Reset values
`define RST_BYTE     8'h00
`define RST_PC       10'h000
`define RST_FLAGS    7'h00

// Interrupt entry address
`define IRQ_VECTOR   10'h004

// Timing: two-cycle instructions hold one dummy cycle
`define BRANCH_CYCLES 2
`define DUMMY_CYCLES  (`BRANCH_CYCLES - 1)

// Opcodes written to the opcode register
`define OP_IDLE          5'h00
`define OP_INVERT_COPY   5'h01
`define OP_BCD_ADJUST    5'h02
`define OP_MINUS_MEM     5'h03
`define OP_MINUS_COPY    5'h04
`define OP_PLUS_MEM      5'h05
`define OP_PLUS_COPY     5'h06
`define OP_SLEEP         5'h07
`define OP_GOTO          5'h08
`define OP_MOV_M2A       5'h09
`define OP_MOV_I2A       5'h0a
`define OP_MOV_A2M       5'h0b
`define OP_OR_MEM2A      5'h0c
`define OP_OR_IMM2A      5'h0d
`define OP_OR_A2MEM      5'h0e
`define OP_SUB_EXIT      5'h0f
`define OP_SUB_EXIT_IMM  5'h10
`define OP_IRQ_EXIT      5'h11
`define OP_ROTL_MEM      5'h12
`define OP_ROTL_COPY     5'h13
`define OP_ROTLF_MEM     5'h14
`define OP_ROTLF_COPY    5'h15
`define OP_ROTR_MEM      5'h16
`define OP_ROTR_COPY     5'h17
`define OP_ROTRF_MEM     5'h18
`define OP_ROTRF_COPY    5'h19
`define OP_SUBB_ACC      5'h1a
`define OP_SUBB_MEM      5'h1b

`endif

// ==== verilog/exec_unit.v ====
// How it works
// RL1: Invert-copy puts complement of memory byte in accumulator, updates null flag only.
// RL2: BCD adjust adds 6 to low nibble when above 9 or half carry.
// RL3: BCD adjust fixes high nibble likewise, stores to memory, alters spill only.
// RL4: Minus-one writes memory or accumulator copy, updating the null flag.
// RL5: Plus-one writes memory or accumulator copy, updating the null flag.
// RL6: Sleep halts, keeps state, clears watchdog, sets sleep flag, clears expiry.
// RL7: Goto loads the program counter, takes two cycles, changes no flag.
// RL8: Transfers move memory, immediate or accumulator, leaving flags unchanged.
// RL9: Idle changes nothing and continues with the next instruction.
// RL10: OR accumulator with memory or immediate into accumulator or memory.
// RL11: Subroutine exit reloads the program counter from the stack.
// RL12: Subroutine exit with immediate also loads the accumulator.
// RL13: Interrupt exit reloads counter, sets enable, serves pending interrupt first.
// RL14: Left rotate moves bit 7 to bit 0, no flag change.
// RL15: Left rotate through spill swaps bit 7 with the spill flag.
// RL16: Right rotate moves bit 0 to bit 7, no flag change.
// RL17: Right rotate through spill swaps bit 0 with the spill flag.
// RL18: Borrow subtract into accumulator updates wrap, null, half and spill.
// RL19: Spill flag clear on negative result, set on zero or positive.
// RL20: Memory form of borrow subtract stores the difference in memory.
// RL21: Null flag set when the 8-bit result is zero.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`include "exec_unit_defines.vh"

module exec_unit (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst_b,
  // Register port
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  // Interrupt request and wake
  input  wire       i_irq_pend,
  input  wire       i_wake,
  // Status outputs
  output reg        o_asleep,
  output reg        o_busy
);

  localparam ST_RUN   = 2'd0;
  localparam ST_DUMMY = 2'd1;
  localparam ST_SLEEP = 2'd2;

  reg [7:0] mem_q [0:31];
  reg [1:0] state_q;
  reg [7:0] acc_q;
  reg [4:0] maddr_q;
  reg [7:0] imm_q;
  reg [9:0] pc_q;
  reg [9:0] stack_q;
  reg [9:0] pc_next_q;
  reg       spill_q;
  reg       half_q;
  reg       null_q;
  reg       wrap_q;
  reg       sleepf_q;
  reg       expiry_q;
  reg       irqen_q;
  reg [7:0] wdog_q;
  reg [7:0] presc_q;

  // Combinational results of the opcode being issued
  reg [7:0] res;
  reg       to_acc;
  reg       to_mem;
  reg       set_null;
  reg       spill_d;
  reg       half_d;
  reg       wrap_d;
  reg       arith;
  reg [8:0] diff;
  reg [4:0] lo_diff;
  reg [3:0] adj;
  reg [8:0] bcd;

  wire [7:0] m = mem_q[maddr_q];
  wire       issue = i_wr && (i_addr == `REG_OPCODE) && (state_q == ST_RUN);
  wire [4:0] op = i_wdata[4:0];

  // Decode and compute result for the issued opcode
  always @* begin
    res      = acc_q;
    to_acc   = 1'b0;
    to_mem   = 1'b0;
    set_null = 1'b0;
    spill_d  = spill_q;
    half_d   = half_q;
    wrap_d   = wrap_q;
    arith    = 1'b0;
    diff    = {1'b0, acc_q} - {1'b0, m} - {8'h00, ~spill_q};
    lo_diff = {1'b0, acc_q[3:0]} - {1'b0, m[3:0]} - {4'h0, ~spill_q};
    adj[0]  = (acc_q[3:0] > 4'h9) || half_q;                      // RL2
    adj[1]  = (acc_q[7:4] > 4'h9) || spill_q;                     // RL3
    adj[3:2] = 2'b00;
    bcd     = {1'b0, acc_q} + {1'b0, adj[1] ? 4'h6 : 4'h0,
                               adj[0] ? 4'h6 : 4'h0};
    case (op)
      `OP_INVERT_COPY: begin
        res = ~m;                                                   // RL1
        to_acc = 1'b1;
        set_null = 1'b1;
      end
      `OP_BCD_ADJUST: begin
        res = bcd[7:0];                                             // RL3
        to_mem = 1'b1;
        spill_d = spill_q | bcd[8];
      end
      `OP_MINUS_MEM, `OP_MINUS_COPY: begin
        res = m - 8'h01;                                            // RL4
        to_mem = (op == `OP_MINUS_MEM);
        to_acc = (op == `OP_MINUS_COPY);
        set_null = 1'b1;
      end
      `OP_PLUS_MEM, `OP_PLUS_COPY: begin
        res = m + 8'h01;                                            // RL5
        to_mem = (op == `OP_PLUS_MEM);
        to_acc = (op == `OP_PLUS_COPY);
        set_null = 1'b1;
      end
      `OP_MOV_M2A: begin
        res = m;                                                    // RL8
        to_acc = 1'b1;
      end
      `OP_MOV_I2A, `OP_SUB_EXIT_IMM: begin
        res = imm_q;                                                // RL12
        to_acc = 1'b1;
      end
      `OP_MOV_A2M: begin
        res = acc_q;                                                // RL8
        to_mem = 1'b1;
      end
      `OP_OR_MEM2A, `OP_OR_A2MEM: begin
        res = acc_q | m;                                            // RL10
        to_acc = (op == `OP_OR_MEM2A);
        to_mem = (op == `OP_OR_A2MEM);
        set_null = 1'b1;
      end
      `OP_OR_IMM2A: begin
        res = acc_q | imm_q;                                        // RL10
        to_acc = 1'b1;
        set_null = 1'b1;
      end
      `OP_ROTL_MEM, `OP_ROTL_COPY: begin
        res = {m[6:0], m[7]};                                       // RL14
        to_mem = (op == `OP_ROTL_MEM);
        to_acc = (op == `OP_ROTL_COPY);
      end
      `OP_ROTLF_MEM, `OP_ROTLF_COPY: begin
        res = {m[6:0], spill_q};                                    // RL15
        spill_d = m[7];
        to_mem = (op == `OP_ROTLF_MEM);
        to_acc = (op == `OP_ROTLF_COPY);
      end
      `OP_ROTR_MEM, `OP_ROTR_COPY: begin
        res = {m[0], m[7:1]};                                       // RL16
        to_mem = (op == `OP_ROTR_MEM);
        to_acc = (op == `OP_ROTR_COPY);
      end
      `OP_ROTRF_MEM, `OP_ROTRF_COPY: begin
        res = {spill_q, m[7:1]};                                    // RL17
        spill_d = m[0];
        to_mem = (op == `OP_ROTRF_MEM);
        to_acc = (op == `OP_ROTRF_COPY);
      end
      `OP_SUBB_ACC, `OP_SUBB_MEM: begin
        res = diff[7:0];                                            // RL18
        to_acc = (op == `OP_SUBB_ACC);
        to_mem = (op == `OP_SUBB_MEM);                              // RL20
        set_null = 1'b1;
        arith = 1'b1;
        spill_d = ~diff[8];                                         // RL19
        half_d = ~lo_diff[4];
        wrap_d = (acc_q[7] ^ m[7]) & (acc_q[7] ^ diff[7]);
      end
      default: begin
        res = acc_q;                                                // RL9
      end
    endcase
  end

  // Data memory writes, from execution or software
  always @(posedge i_clk) begin
    if (issue && to_mem) begin
      mem_q[maddr_q] <= res;
    end else if (i_wr && (i_addr == `REG_MDATA) && (state_q != ST_SLEEP)) begin
      mem_q[maddr_q] <= i_wdata;
    end
  end

  // Sequencer, accumulator, flags, counter and stack
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q   <= ST_RUN;
      acc_q     <= `RST_BYTE;
      maddr_q   <= 5'h00;
      imm_q     <= `RST_BYTE;
      pc_q      <= `RST_PC;
      stack_q   <= `RST_PC;
      pc_next_q <= `RST_PC;
      {irqen_q, expiry_q, sleepf_q, wrap_q, null_q, half_q, spill_q}
                <= `RST_FLAGS;
      wdog_q    <= `RST_BYTE;
      presc_q   <= `RST_BYTE;
    end else begin
      case (state_q)
        ST_RUN: begin
          // Watchdog runs only while the clock runs
          presc_q <= presc_q + 8'h01;
          if (presc_q == 8'hff) begin
            wdog_q <= wdog_q + 8'h01;
          end
          if (issue) begin
            if (to_acc) begin
              acc_q <= res;
            end
            if (set_null) begin
              null_q <= (res == 8'h00);                             // RL21
            end
            spill_q <= spill_d;
            if (arith) begin
              half_q <= half_d;
              wrap_q <= wrap_d;
            end
            case (op)
              `OP_SLEEP: begin
                state_q  <= ST_SLEEP;                               // RL6
                wdog_q   <= `RST_BYTE;
                presc_q  <= `RST_BYTE;
                sleepf_q <= 1'b1;
                expiry_q <= 1'b0;
                pc_q     <= pc_q + 10'h001;
              end
              `OP_GOTO: begin
                pc_next_q <= {maddr_q[1:0], imm_q};                 // RL7
                state_q   <= ST_DUMMY;
              end
              `OP_SUB_EXIT, `OP_SUB_EXIT_IMM: begin
                pc_next_q <= stack_q;                               // RL11
                state_q   <= ST_DUMMY;
              end
              `OP_IRQ_EXIT: begin
                irqen_q <= 1'b1;                                    // RL13
                state_q <= ST_DUMMY;
                if (i_irq_pend) begin
                  // Pending request served before main program resumes
                  pc_next_q <= `IRQ_VECTOR;                         // RL13
                  irqen_q   <= 1'b0;
                end else begin
                  pc_next_q <= stack_q;
                end
              end
              default: begin
                pc_q <= pc_q + 10'h001;                             // RL9
              end
            endcase
          end else if (i_wr) begin
            case (i_addr)
              `REG_MADDR:  maddr_q <= i_wdata[4:0];
              `REG_IMM:    imm_q <= i_wdata;
              `REG_ACC:    acc_q <= i_wdata;
              `REG_STATUS: begin
                {irqen_q, expiry_q, sleepf_q, wrap_q, null_q, half_q,
                 spill_q} <= i_wdata[6:0];
              end
              `REG_PCL:    pc_q[7:0] <= i_wdata;
              `REG_PCH:    pc_q[9:8] <= i_wdata[1:0];
              `REG_STACKL: stack_q[7:0] <= i_wdata;
              `REG_STACKH: stack_q[9:8] <= i_wdata[1:0];
              default: begin
                acc_q <= acc_q;
              end
            endcase
          end
          // Overflow set comes last so it beats a status write
          // in the same cycle; a sleep issue still clears it
          if (presc_q == 8'hff && wdog_q == 8'hff
              && !(issue && op == `OP_SLEEP)) begin
            expiry_q <= 1'b1;
          end
        end
        ST_DUMMY: begin
          // Dummy cycle while the new address loads
          pc_q    <= pc_next_q;                                     // RL7
          state_q <= ST_RUN;
          if (pc_next_q == `IRQ_VECTOR && irqen_q == 1'b0
              && i_irq_pend) begin
            stack_q <= stack_q;
          end
        end
        ST_SLEEP: begin
          // Clock stopped: memory, registers and counter all held
          if (i_wake) begin
            state_q <= ST_RUN;                                      // RL6
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Status flags and one-cycle read data
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata  <= `RST_BYTE;
      o_asleep <= 1'b0;
      o_busy   <= 1'b0;
    end else begin
      // Drops on the wake edge, together with the state
      o_asleep <= (state_q == ST_SLEEP && !i_wake)
                  || (issue && op == `OP_SLEEP);
      o_busy   <= issue && (op == `OP_GOTO || op == `OP_SUB_EXIT
                  || op == `OP_SUB_EXIT_IMM || op == `OP_IRQ_EXIT);
      if (i_rd) begin
        case (i_addr)
          `REG_MADDR:  o_rdata <= {3'b000, maddr_q};
          `REG_IMM:    o_rdata <= imm_q;
          `REG_ACC:    o_rdata <= acc_q;
          `REG_STATUS: begin
            o_rdata <= {state_q != ST_RUN, irqen_q, expiry_q, sleepf_q,
                        wrap_q, null_q, half_q, spill_q};
          end
          `REG_PCL:    o_rdata <= pc_q[7:0];
          `REG_PCH:    o_rdata <= {6'h00, pc_q[9:8]};
          `REG_MDATA:  o_rdata <= m;
          `REG_WDOG:   o_rdata <= wdog_q;
          `REG_STACKL: o_rdata <= stack_q[7:0];
          `REG_STACKH: o_rdata <= {6'h00, stack_q[9:8]};
          default:     o_rdata <= 8'h00;
        endcase
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

endmodule

// ==== tb/exec_unit_assertions.sv ====
`timescale 1ns/1ns
`include "exec_unit_defines.vh"

module exec_unit_checker (
  // Clock and reset
  input wire       i_clk,
  input wire       i_rst_b,
  // Register port
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  // Control and status
  input wire       i_irq_pend,
  input wire       i_wake,
  input wire       o_asleep,
  input wire       o_busy
);
  // Accepted opcode writes, split by kind
  wire [4:0] op    = i_wdata[4:0];
  wire       issue = i_wr && i_addr == `REG_OPCODE && !o_busy && !o_asleep;
  wire       exits = op == `OP_SUB_EXIT || op == `OP_SUB_EXIT_IMM ||
                     op == `OP_IRQ_EXIT;
  wire       brch  = exits || op == `OP_GOTO;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_goto_dummy:
    assert property (issue && op == `OP_GOTO |=> o_busy ##1 !o_busy)
    else $error("Goto without exactly one dummy cycle");
  a_exit_dummy:
    assert property (issue && exits |=> o_busy ##1 !o_busy)
    else $error("Return without exactly one dummy cycle");
  a_busy_cause:
    assert property (!(issue && brch) |=> !o_busy)
    else $error("Busy without a branch issue");
  a_sleep_entry:
    assert property (issue && op == `OP_SLEEP |=> o_asleep && !o_busy)
    else $error("Sleep issue did not halt");
  a_sleep_hold:
    assert property (o_asleep && !i_wake |=> o_asleep)
    else $error("Left sleep without wake");
  a_awake_stay:
    assert property (!o_asleep && !(issue && op == `OP_SLEEP) |=> !o_asleep)
    else $error("Asleep without a sleep issue");
  a_sleep_quiet:
    assert property (o_asleep |-> !o_busy)
    else $error("Execution while asleep");
  a_sleep_ignore:
    assert property (o_asleep && i_wr && !i_wake |=> !o_busy && o_asleep)
    else $error("Write acted while asleep");
endmodule

bind exec_unit exec_unit_checker u_exec_unit_checker (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_irq_pend(i_irq_pend),
  .i_wake(i_wake), .o_asleep(o_asleep), .o_busy(o_busy));

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`include "exec_unit_defines.vh"

module testbench;
  reg        i_clk;
  reg        i_rst_b;
  reg  [3:0] i_addr;
  reg  [7:0] i_wdata;
  reg        i_wr;
  reg        i_rd;
  reg        i_irq_pend;
  reg        i_wake;
  wire [7:0] o_rdata;
  wire       o_asleep;
  wire       o_busy;
  integer    fail_count;
  integer    n_compared;
  integer    cycles;
  reg  [7:0] v;

  // Block under test
  exec_unit u_exec_unit (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_irq_pend(i_irq_pend),
    .i_wake(i_wake), .o_asleep(o_asleep), .o_busy(o_busy));

  // 250 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // Hang guard
  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end

  task end_of_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task chk(input [8*8-1:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // One write or read cycle, strobe low between
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
    end
  endtask

  task rd(input [3:0] a);
    begin
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1 v = o_rdata;
    end
  endtask

  // Load operands, issue, compare acc, memory and status
  task run(input [4:0] op, input [55:0] c);
    begin
      wr(`REG_IMM, c[31:24]);
      wr(`REG_MADDR, 8'h05);
      wr(`REG_MDATA, c[47:40]);
      wr(`REG_ACC, c[55:48]);
      wr(`REG_STATUS, c[39:32]);
      wr(`REG_OPCODE, {3'h0, op});
      rd(`REG_ACC);
      chk("acc", v, c[23:16]);
      rd(`REG_MDATA);
      chk("mem", v, c[15:8]);
      rd(`REG_STATUS);
      chk("status", v, c[7:0]);
    end
  endtask

  task pc(input [7:0] lo, input [7:0] hi);
    begin
      rd(`REG_PCL);
      chk("pcl", v, lo);
      rd(`REG_PCH);
      chk("pch", v, hi);
    end
  endtask

  task t_arith;
    begin
      run(`OP_INVERT_COPY, 56'h55_ff_01_00_00_ff_05);
      run(`OP_INVERT_COPY, 56'h00_0f_04_00_f0_0f_00);
      run(`OP_BCD_ADJUST, 56'h3c_00_00_00_3c_42_00);
      run(`OP_BCD_ADJUST, 56'h91_00_02_00_91_97_02);
      run(`OP_BCD_ADJUST, 56'h12_00_00_00_12_12_00);
      run(`OP_BCD_ADJUST, 56'ha5_00_04_00_a5_05_05);
      run(`OP_BCD_ADJUST, 56'h20_00_01_00_20_80_01);
      run(`OP_MINUS_MEM, 56'h77_01_00_00_77_00_04);
      run(`OP_MINUS_COPY, 56'h77_00_04_00_ff_00_00);
      run(`OP_PLUS_MEM, 56'h77_ff_00_00_77_00_04);
      run(`OP_PLUS_COPY, 56'h00_7f_04_00_80_7f_00);
      run(`OP_SUBB_ACC, 56'h10_01_01_00_0f_01_01);
      run(`OP_SUBB_ACC, 56'h05_05_00_00_ff_05_00);
      run(`OP_SUBB_ACC, 56'h05_05_01_00_00_05_07);
      run(`OP_SUBB_ACC, 56'h80_01_01_00_7f_01_09);
      run(`OP_SUBB_MEM, 56'h80_01_01_00_80_7f_09);
      $display("arith test done");
    end
  endtask

  task t_logic;
    begin
      run(`OP_MOV_M2A, 56'h00_3c_0f_00_3c_3c_0f);
      run(`OP_MOV_I2A, 56'h00_3c_0f_a1_a1_3c_0f);
      run(`OP_MOV_A2M, 56'h00_99_0b_00_00_00_0b);
      run(`OP_IDLE, 56'h12_34_0b_56_12_34_0b);
      run(`OP_OR_MEM2A, 56'h0f_f0_04_00_ff_f0_00);
      run(`OP_OR_IMM2A, 56'h00_f0_00_00_00_f0_04);
      run(`OP_OR_A2MEM, 56'h81_18_01_00_81_99_01);
      run(`OP_ROTL_MEM, 56'h00_81_0e_00_00_03_0e);
      run(`OP_ROTL_COPY, 56'h00_81_0e_00_03_81_0e);
      run(`OP_ROTLF_MEM, 56'h00_81_00_00_00_02_01);
      run(`OP_ROTLF_COPY, 56'h00_40_01_00_81_40_00);
      run(`OP_ROTR_MEM, 56'h00_81_0e_00_00_c0_0e);
      run(`OP_ROTR_COPY, 56'h00_02_0e_00_01_02_0e);
      run(`OP_ROTRF_MEM, 56'h00_81_00_00_00_40_01);
      run(`OP_ROTRF_COPY, 56'h00_02_01_00_81_02_00);
      $display("logic test done");
    end
  endtask

  task t_branch;
    begin
      wr(`REG_OPCODE, {3'h0, `OP_GOTO});
      #1 chk("busy", {7'h00, o_busy}, 8'h01);
      run(`OP_GOTO, 56'h12_34_0f_c3_12_34_0f);
      pc(8'hc3, 8'h01);
      wr(`REG_STACKL, 8'h5a);
      wr(`REG_STACKH, 8'h02);
      run(`OP_SUB_EXIT, 56'h12_34_0f_00_12_34_0f);
      pc(8'h5a, 8'h02);
      run(`OP_SUB_EXIT_IMM, 56'h12_34_0f_77_77_34_0f);
      run(`OP_IRQ_EXIT, 56'h12_34_0f_00_12_34_4f);
      pc(8'h5a, 8'h02);
      @(posedge i_clk);
      i_irq_pend <= 1'b1;
      run(`OP_IRQ_EXIT, 56'h12_34_0f_00_12_34_0f);
      pc(8'h04, 8'h00);
      @(posedge i_clk);
      i_irq_pend <= 1'b0;
      run(`OP_IDLE, 56'h12_34_0f_00_12_34_0f);
      pc(8'h05, 8'h00);
      $display("branch test done");
    end
  endtask

  task t_sleep;
    integer n;
    begin
      repeat (600) @(posedge i_clk);
      rd(`REG_WDOG);
      chk("wdog run", {7'h00, v != 8'h00}, 8'h01);
      run(`OP_SLEEP, 56'h12_34_0f_00_12_34_9f);
      rd(`REG_WDOG);
      chk("wdog", v, 8'h00);
      wr(`REG_ACC, 8'hee);
      rd(`REG_ACC);
      chk("acc held", v, 8'h12);
      chk("asleep", {7'h00, o_asleep}, 8'h01);
      @(posedge i_clk);
      i_wake <= 1'b1;
      n = 0;
      while (o_asleep === 1'b1 && n < 20) begin
        @(posedge i_clk);
        #1 n = n + 1;
      end
      chk("awake", {7'h00, o_asleep}, 8'h00);
      @(posedge i_clk);
      i_wake <= 1'b0;
      $display("sleep test done");
    end
  endtask

  // Reset, then the scenarios
  initial begin
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    i_rst_b = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_irq_pend = 1'b0;
    i_wake = 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_arith;
    t_logic;
    t_branch;
    t_sleep;
    end_of_test;
  end
endmodule
